// [dv/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb_top;
  localparam [15:0] RLD = 16'h0004;
  reg        clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, demod = 1'h0, edg = 1'h0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00, ncap = 8'h00, ncirq = 8'h00;
  wire [7:0] rdata, abs_addr;
  wire [3:0] p3out, p3irq;
  wire       cap, tirq, cirq, ext;
  wire [15:0] capval;
  integer    miscompares = 0, n_tests = 0, t, k, n;
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    ncap <= ncap + cap;
    ncirq <= ncirq + cirq;
  end
  wtc_timer16_ctrl #(.WIDTH(16)) i_wtc_timer16_ctrl (.CLK_I(clk), .RST_N_I(rst_n),
    .WR_EN_I(wr), .RD_EN_I(rd), .ADDR_I(addr), .WDATA_I(wdata), .DEMOD_MODE_I(demod),
    .EDGE_I(edg), .RELOAD_I(RLD), .PORT3_IN_I(4'h9), .PORT3_LATCH_I(4'h5),
    .RDATA_O(rdata), .ABS_ADDR_O(abs_addr), .BANK_HIT_O(), .EXT_ACCESS_O(ext),
    .PORT3_OUT_O(p3out), .PORT3_IRQ_O(p3irq), .CAPTURE_O(cap), .CAPTURE_VAL_O(capval),
    .TIMEOUT_IRQ_O(tirq),
    .CAPTURE_IRQ_O(cirq), .COUNT_O());
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  end
  endtask
  task rd_reg(input [7:0] a, output [7:0] v);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    #1 v = rdata;
  end
  endtask
  // Bounded wait; 600 means no timeout came
  task wtmo;
  begin
    t = 0;
    @(posedge clk);
    #1;
    while (tirq !== 1'h1 && t < 600)
    begin
      @(posedge clk);
      #1 t++;
    end
  end
  endtask
  task edge2;
  begin
    repeat (2)
    begin
      @(posedge clk);
      edg <= ~edg;
      repeat (6) @(posedge clk);
    end
  end
  endtask
  task stop_test;
  begin
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  initial
  begin
    #100000 miscompares++;
    stop_test;
  end
  reg [7:0] v;
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(8'hfd, v); `CHK(v, 8'h00)
    wr_reg(8'hfd, 8'h20); rd_reg(8'h03, v); `CHK(v, 8'h59)
    `CHK({ext, abs_addr}, 9'h023)
    wr_reg(8'hfd, 8'h01); rd_reg(8'h02, v); `CHK(v, 8'h00)
    wr_reg(8'hfd, 8'h3d); rd_reg(8'hfd, v); `CHK(v, 8'h3d)
    rd_reg(8'h02, v); `CHK(v, 8'h00)
    `CHK({ext, abs_addr}, 9'h132)
    wr_reg(8'h03, 8'hff); rd_reg(8'h03, v); `CHK(v, 8'h00)
    `CHK(p3out, 4'h5)
    `CHK(p3irq, 4'h9)
    for (k = 0; k < 4; k++)
    begin
      wr_reg(8'h02, {3'h4, k[1:0], 3'h2});
      wtmo; wtmo; wtmo; `CHK(t, ((RLD + 1) << k) - 1)
    end
    rd_reg(8'h02, v); `CHK(v, 8'hba)
    wr_reg(8'h02, 8'hba); rd_reg(8'h02, v); `CHK(v, 8'h9a)
    wr_reg(8'h02, 8'hda); wtmo; rd_reg(8'h02, v); `CHK(v, 8'h7a)
    wtmo; `CHK(t, 600)
    wr_reg(8'h02, 8'h81); #1;
    n = 0;
    repeat (40)
    begin
      v[0] = p3out[1];
      @(posedge clk);
      #1 n += (p3out[1] !== v[0]);
    end
    `CHK(n > 1, 1'h1)
    wr_reg(8'h02, 8'h00); repeat (3) @(posedge clk); `CHK(p3out, 4'h5)
    demod <= 1'h1;
    wr_reg(8'h02, 8'h84); edge2; `CHK(ncap, 8'h02)
    `CHK(capval, RLD - 16'h0006)
    wr_reg(8'h02, 8'h04); wr_reg(8'h02, 8'hc4); edge2; `CHK(ncap, 8'h03)
    `CHK(ncirq, 8'h03)
    stop_test;
  end
endmodule
bind wtc_timer16_ctrl wtc_props #(.WIDTH(WIDTH)) i_wtc_props (.CLK_I, .RST_N_I, .WR_EN_I,
  .RD_EN_I, .ADDR_I, .WDATA_I, .PORT3_IN_I, .PORT3_LATCH_I, .RDATA_O, .BANK_HIT_O,
  .PORT3_OUT_O, .PORT3_IRQ_O, .TIMEOUT_IRQ_O, .CAPTURE_IRQ_O, .COUNT_O);

// [dv/wtc_props_properties.sv]
`timescale 1ns/1ps
module wtc_props #(
  parameter WIDTH = 16
) (
  input wire             CLK_I,
  input wire             RST_N_I,
  input wire             WR_EN_I,
  input wire             RD_EN_I,
  input wire [7:0]       ADDR_I,
  input wire [7:0]       WDATA_I,
  input wire [3:0]       PORT3_IN_I,
  input wire [3:0]       PORT3_LATCH_I,
  input wire [7:0]       RDATA_O,
  input wire             BANK_HIT_O,
  input wire [3:0]       PORT3_OUT_O,
  input wire [3:0]       PORT3_IRQ_O,
  input wire             TIMEOUT_IRQ_O,
  input wire             CAPTURE_IRQ_O,
  input wire [WIDTH-1:0] COUNT_O
);
  // ----------------------------------------
  // Shadow of what software wrote
  // ----------------------------------------
  reg  [7:0] ptr;
  reg  [7:0] ctl;
  wire       acc = (RD_EN_I || WR_EN_I) && ADDR_I[7:4] == 4'h0;
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ptr <= 8'h00;
      ctl <= 8'h00;
    end
    else if (WR_EN_I)
    begin
      if (ADDR_I == 8'hfd)
        ptr <= WDATA_I;
      if (acc && ADDR_I[3:0] == 4'h2 && ptr[3:0] == 4'hd)
        ctl <= WDATA_I;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_ptr_read:
    assert property (RD_EN_I && ADDR_I == 8'hfd |=> RDATA_O == $past(ptr))
    else $error("pointer readback wrong");
  a_bank_hit:
    assert property (acc |=> BANK_HIT_O == $past(ptr[3:0] == 4'hd || ptr[3:0] == 4'hf))
    else $error("bank hit wrong");
  a_rsvd_zero:
    assert property (RD_EN_I && acc && ADDR_I[3:0] == 4'h3 && ptr[3:0] == 4'hd
      |=> RDATA_O == 8'h00) else $error("reserved slot not zero");
  a_stop_hold:
    assert property (!ctl[7] && !$past(ctl[7]) && !$past(ctl[7], 2) |-> $stable(COUNT_O))
    else $error("stopped counter moved");
  a_irq_copy:
    assert property ($past(RST_N_I) |-> PORT3_IRQ_O == $past(PORT3_IN_I))
    else $error("input lines not copied");
  a_fixed_out:
    assert property ($past(RST_N_I) |-> {PORT3_OUT_O[3:2], PORT3_OUT_O[0]}
      == $past({PORT3_LATCH_I[3:2], PORT3_LATCH_I[0]})) else $error("fixed outputs wrong");
  a_pin_latch:
    assert property ($past(RST_N_I) && !ctl[0] && !$past(ctl[0])
      |-> PORT3_OUT_O[1] == $past(PORT3_LATCH_I[1])) else $error("shared pin not latch");
  a_tmo_mask:
    assert property (TIMEOUT_IRQ_O |-> ctl[1] || $past(ctl[1]))
    else $error("timeout irq while masked");
  a_cap_mask:
    assert property (CAPTURE_IRQ_O |-> ctl[2] || $past(ctl[2]))
    else $error("capture irq while masked");
endmodule

// [hw/wtc_defines.vh]
`ifndef WTC_DEFINES_VH
`define WTC_DEFINES_VH

// ----------------------------------------
// Register addresses and banking
// ----------------------------------------
`define WTC_ADDR_POINTER     8'hfd
`define WTC_BANK_NORMAL      4'h0
`define WTC_BANK_D           4'hd
`define WTC_BANK_F           4'hf
`define WTC_IDX_BANK_D_ZERO  4'h0
`define WTC_IDX_BANK_D_ONE   4'h1
`define WTC_IDX_CONTROL      4'h2
`define WTC_IDX_RESERVED     4'h3
`define WTC_IDX_PORT3        4'h3

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define WTC_BIT_RUN          7
`define WTC_BIT_SINGLE       6
`define WTC_BIT_TIMEOUT      5
`define WTC_BIT_PRE_HI       4
`define WTC_BIT_PRE_LO       3
`define WTC_BIT_CAP_INT      2
`define WTC_BIT_TMO_INT      1
`define WTC_BIT_PIN_SRC      0
`define WTC_CONTROL_RESET    8'h00
`define WTC_POINTER_RESET    8'h00

// ----------------------------------------
// Port 3 layout
// ----------------------------------------
`define WTC_SHARED_PIN_IDX   1

`endif

// [hw/wtc_timer16_ctrl.v]
`timescale 1ns/1ps
`include "wtc_defines.vh"
module wtc_timer16_ctrl #(
  parameter WIDTH = 16
) (
  input  wire             CLK_I,
  input  wire             RST_N_I,
  input  wire             WR_EN_I,
  input  wire             RD_EN_I,
  input  wire [7:0]       ADDR_I,
  input  wire [7:0]       WDATA_I,
  input  wire             DEMOD_MODE_I,
  input  wire             EDGE_I,
  input  wire [WIDTH-1:0] RELOAD_I,
  input  wire [3:0]       PORT3_IN_I,
  input  wire [3:0]       PORT3_LATCH_I,
  output reg  [7:0]       RDATA_O,
  output reg  [7:0]       ABS_ADDR_O,
  output reg              BANK_HIT_O,
  output reg              EXT_ACCESS_O,
  output reg  [3:0]       PORT3_OUT_O,
  output reg  [3:0]       PORT3_IRQ_O,
  output reg              CAPTURE_O,
  output reg  [WIDTH-1:0] CAPTURE_VAL_O,
  output reg              TIMEOUT_IRQ_O,
  output reg              CAPTURE_IRQ_O,
  output reg  [WIDTH-1:0] COUNT_O
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  reg  [7:0]       bank_pointer;
  reg  [7:0]       control;
  reg  [WIDTH-1:0] count;
  reg  [2:0]       pre_cnt;
  reg              timer_out;
  reg              edge_lock;
  reg              edge_d;

  // Short working register address 0..f mapped through the pointer
  function [7:0] map_addr;
    input [7:0] a;
    input [7:0] p;
    begin
      if (a[7:4] == 4'h0)
        map_addr = {p[7:4], a[3:0]};
      else
        map_addr = a;
    end
  endfunction

  // Lowest sixteen go to the expanded bank when low nibble nonzero
  function is_bank;
    input [7:0] a;
    input [7:0] p;
    begin
      is_bank = (a[7:4] == 4'h0) && (p[3:0] != `WTC_BANK_NORMAL);
    end
  endfunction

  wire       bank_acc = is_bank(ADDR_I, bank_pointer);
  wire       bank_d   = bank_pointer[3:0] == `WTC_BANK_D;
  wire       bank_ok  = bank_d || (bank_pointer[3:0] == `WTC_BANK_F);
  wire       ctl_sel  = bank_acc && bank_d && (ADDR_I[3:0] == `WTC_IDX_CONTROL);
  wire       ptr_sel  = ADDR_I == `WTC_ADDR_POINTER;
  wire [1:0] prescale = control[`WTC_BIT_PRE_HI:`WTC_BIT_PRE_LO];
  wire       run      = control[`WTC_BIT_RUN];

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  reg  [2:0] pre_mask;
  always @*
  begin
    case (prescale)
      2'b00:   pre_mask = 3'h0;
      2'b01:   pre_mask = 3'h1;
      2'b10:   pre_mask = 3'h3;
      2'b11:   pre_mask = 3'h7;
      default: pre_mask = 3'h0;
    endcase
  end

  wire tick     = run && ((pre_cnt & pre_mask) == pre_mask);
  wire terminal = tick && !DEMOD_MODE_I && (count == {WIDTH{1'b0}});
  wire rise     = EDGE_I ^ edge_d;
  wire capture  = run && DEMOD_MODE_I && rise && !edge_lock;
  wire tmo_set  = terminal;
  wire tmo_clr  = WR_EN_I && ctl_sel && WDATA_I[`WTC_BIT_TIMEOUT];

  reg  [7:0] next_control;
  always @*
  begin
    next_control = control;
    if (WR_EN_I && ctl_sel)
    begin
      next_control = {WDATA_I[7:6], control[5], WDATA_I[4:0]};
      if (tmo_clr)
        next_control[`WTC_BIT_TIMEOUT] = 1'b0;
    end
    // Timeout arriving with a clear still lands
    if (tmo_set)
      next_control[`WTC_BIT_TIMEOUT] = 1'b1;
    // Single pass stops the counter itself
    if (terminal && control[`WTC_BIT_SINGLE])
      next_control[`WTC_BIT_RUN] = 1'b0;
  end

  // ----------------------------------------
  // Software visible registers
  // ----------------------------------------
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      bank_pointer <= `WTC_POINTER_RESET;
      control      <= `WTC_CONTROL_RESET;
    end
    else
    begin
      control <= next_control;
      // Pointer sits outside the swapped window, so it is reachable from any bank
      if (WR_EN_I && ptr_sel)
        bank_pointer <= WDATA_I;
    end
  end

  // ----------------------------------------
  // Down counter and timer output
  // ----------------------------------------
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      count     <= {WIDTH{1'b0}};
      pre_cnt   <= 3'h0;
      timer_out <= 1'b0;
    end
    else
    begin
      // Prescaler restarts with the counter so the first tick is full length
      pre_cnt <= run ? pre_cnt + 3'h1 : 3'h0;
      if (terminal)
      begin
        count     <= RELOAD_I;
        timer_out <= ~timer_out;
      end
      else if (capture)
        count <= RELOAD_I;
      else if (tick)
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // Edge detection in demodulation
  // ----------------------------------------
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      edge_lock <= 1'b0;
      edge_d    <= 1'b0;
    end
    else
    begin
      edge_d <= EDGE_I;
      // Lock releases when run is cleared, so software re-arms by restart
      if (!run)
        edge_lock <= 1'b0;
      else if (capture && control[`WTC_BIT_SINGLE])
        edge_lock <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  reg [7:0] next_rdata;
  always @*
  begin
    next_rdata = 8'h00;
    if (ptr_sel)
      next_rdata = bank_pointer;
    else if (ctl_sel)
      next_rdata = control;
    else if (!bank_acc && ADDR_I[3:0] == `WTC_IDX_PORT3 && ADDR_I[7:4] == 4'h0)
      next_rdata = {PORT3_OUT_O, PORT3_IN_I};
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  // Held between reads so a slow master may sample late
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      RDATA_O <= 8'h00;
    end
    else
    begin
      if (RD_EN_I)
        RDATA_O <= next_rdata;
    end
  end

  // ----------------------------------------
  // Address mapping status
  // ----------------------------------------
  // Registered every cycle, not only on an access
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ABS_ADDR_O   <= 8'h00;
      BANK_HIT_O   <= 1'b0;
      EXT_ACCESS_O <= 1'b0;
    end
    else
    begin
      ABS_ADDR_O   <= map_addr(ADDR_I, bank_pointer);
      BANK_HIT_O   <= bank_acc && bank_ok;
      EXT_ACCESS_O <= bank_acc;
    end
  end

  // ----------------------------------------
  // Port 3 lines
  // ----------------------------------------
  // Only the shared pin can be taken over by the timer
  wire [3:0] next_port3_out;
  genvar     gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_port3
      if (gi == `WTC_SHARED_PIN_IDX)
      begin : g_shared
        assign next_port3_out[gi] = control[`WTC_BIT_PIN_SRC] ? timer_out : PORT3_LATCH_I[gi];
      end
      else
      begin : g_fixed
        assign next_port3_out[gi] = PORT3_LATCH_I[gi];
      end
    end
  endgenerate

  // Inputs pass through unmasked; interrupt routing sits elsewhere
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      PORT3_OUT_O <= 4'h0;
      PORT3_IRQ_O <= 4'h0;
    end
    else
    begin
      PORT3_OUT_O <= next_port3_out;
      PORT3_IRQ_O <= PORT3_IN_I;
    end
  end

  // ----------------------------------------
  // Event pulses and capture
  // ----------------------------------------
  // Pulses last one cycle; software sees the flag, not these
  always @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CAPTURE_O     <= 1'b0;
      CAPTURE_VAL_O <= {WIDTH{1'b0}};
      TIMEOUT_IRQ_O <= 1'b0;
      CAPTURE_IRQ_O <= 1'b0;
      COUNT_O       <= {WIDTH{1'b0}};
    end
    else
    begin
      CAPTURE_O     <= capture;
      // Capture value frozen until the next capture
      if (capture)
        CAPTURE_VAL_O <= count;
      TIMEOUT_IRQ_O <= tmo_set && control[`WTC_BIT_TMO_INT];
      CAPTURE_IRQ_O <= capture && control[`WTC_BIT_CAP_INT];
      COUNT_O       <= count;
    end
  end

endmodule
